// ==== core/dhlcd_pkg.sv ====
// constants shared by the two-half lcd host port and its command queue
package dhlcd_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ     = 200;
  localparam int OP_TIME_NS  = 40;
  localparam int OP_CYCLES   = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_TIME_NS = 1000;
  localparam int RST_CYCLES  = (RST_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W       = 10;

  // ---------------------------------------------------------------
  // memory geometry
  // ---------------------------------------------------------------
  localparam int              HALVES     = 2;
  localparam int              HALF_LEFT  = 0;
  localparam int              HALF_RIGHT = 1;
  localparam int              PAGES      = 4;
  localparam logic [6:0]      COL_LIMIT  = 7'h50;
  localparam int              RAM_WORDS  = PAGES * 80;
  localparam int              ADDR_W     = 9;
  localparam int              DATA_W     = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [6:0]      COL_RST    = 7'h00;
  localparam logic [1:0]      PAGE_RST   = 2'h0;
  localparam logic [4:0]      START_RST  = 5'h00;
  localparam logic [7:0]      LATCH_RST  = 8'h00;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0]      CMD_COL_MASK   = 8'h80;
  localparam logic [7:0]      CMD_COL_VAL    = 8'h00;
  localparam logic [7:0]      CMD_PAGE_MASK  = 8'hFC;
  localparam logic [7:0]      CMD_PAGE_VAL   = 8'hB8;
  localparam logic [7:0]      CMD_START_MASK = 8'hE0;
  localparam logic [7:0]      CMD_START_VAL  = 8'hC0;
  localparam logic [7:0]      CMD_DISP_MASK  = 8'hFE;
  localparam logic [7:0]      CMD_DISP_VAL   = 8'hAE;
  localparam logic [7:0]      CMD_FULL_MASK  = 8'hFF;
  localparam logic [7:0]      CMD_RMW        = 8'hE0;
  localparam logic [7:0]      CMD_END        = 8'hEE;
  localparam logic [7:0]      CMD_SWRST      = 8'hE2;

  // ---------------------------------------------------------------
  // status byte bit positions
  // ---------------------------------------------------------------
  localparam int              ST_BUSY  = 7;
  localparam int              ST_OFF   = 5;
  localparam int              ST_RESET = 4;
  localparam int              ST_PEND  = 3;

  // ---------------------------------------------------------------
  // queue entry layout: {half mask, rs, rw, data}
  // ---------------------------------------------------------------
  localparam int              ENT_W        = 12;
  localparam int              ENT_MASK_LSB = 10;
  localparam int              ENT_RS       = 9;
  localparam int              ENT_RW       = 8;
  localparam int              FIFO_DEPTH   = 8;

endpackage

// ==== core/dhlcd_fifo.sv ====
// parameterised valid/ready fifo for queued host accesses
`timescale 1ns/1ps
module dhlcd_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_r != (PW+1)'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem[rd_ptr_r];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // ---------------------------------------------------------------
  // pointers and fill level
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// ==== core/dhlcd_host_port.sv ====
// host port, command engine and display ram of the two-half lcd controller
// Contract
// - rs/rw pick data, status or command access
// - left select high: left half responds
// - right select high: right half responds
// - one shared 8-bit bus for all bytes
// - while busy, only status reads accepted
// - status read shows busy on bit 7
// - start line set only by command
// - 7-bit column counter addresses ram accesses
// - column advances on each data access; code: reads in read-modify-write mode do not advance it
// - column saturates at 50h
// - set-column command loads column counter
// - ram holds one bit per pixel
// - 2-bit page register addresses ram accesses
// - data read returns latch, then refills it
// - read-modify-write: only writes advance column
`timescale 1ns/1ps
module dhlcd_host_port (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_register_select,
  input  wire logic       i_read_not_write,
  input  wire logic       i_left_half_select,
  input  wire logic       i_right_half_select,
  input  wire logic [7:0] i_bus_data,
  output logic      [7:0] o_bus_data,
  output logic            o_bus_oe_n,
  input  wire logic       i_pix_half,
  input  wire logic [4:0] i_pix_row,
  input  wire logic [6:0] i_pix_col,
  output logic            o_pix,
  output logic      [4:0] o_start_line_left,
  output logic      [4:0] o_start_line_right,
  output logic            o_display_on_left,
  output logic            o_display_on_right
);

  typedef enum logic {DHLCD_IDLE, DHLCD_HOLD} dhlcd_eng_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [dhlcd_pkg::ADDR_W-1:0] ram_addr(
    input logic [1:0] pg,
    input logic [6:0] col
  );
    ram_addr = dhlcd_pkg::ADDR_W'(int'(pg) * int'(dhlcd_pkg::COL_LIMIT) + int'(col));
  endfunction

  function automatic logic cmd_is(
    input logic [7:0] code,
    input logic [7:0] mask,
    input logic [7:0] val
  );
    cmd_is = ((code & mask) == val);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  logic [1:0]  sel_d_r;
  logic        rs_s;
  logic        rw_s;
  logic [1:0]  sel_s;
  logic [7:0]  din_s;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_register_select, i_read_not_write, i_right_half_select,
                  i_left_half_select, i_bus_data};
      sync2_r <= sync1_r;
    end
  end

  assign rs_s  = sync2_r[11];
  assign rw_s  = sync2_r[10];
  assign sel_s = sync2_r[9:8];
  assign din_s = sync2_r[7:0];

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_d_r <= '0;
    end else begin
      sel_d_r <= sel_s;
    end
  end

  // ---------------------------------------------------------------
  // access detection: an access ends on the falling select
  // ---------------------------------------------------------------
  logic [1:0]  acc_mask;
  logic        acc_evt;
  logic        acc_status;
  logic        busy;
  logic        rst_act_r;
  logic        q_in_ready;
  logic        q_in_valid;
  logic [11:0] q_in_data;
  logic        q_out_valid;
  logic        q_out_ready;
  logic [11:0] q_out_data;

  assign acc_mask   = sel_d_r & ~sel_s;
  assign acc_evt    = (acc_mask != 2'b00);
  assign acc_status = ~rs_s & rw_s;
  assign busy       = ~q_in_ready | rst_act_r;
  assign q_in_valid = acc_evt & ~acc_status & ~busy;
  assign q_in_data  = {acc_mask, rs_s, rw_s, din_s};

  dhlcd_fifo #(
    .WIDTH (dhlcd_pkg::ENT_W),
    .DEPTH (dhlcd_pkg::FIFO_DEPTH)
  ) u_queue (
    .i_clk_sys   (i_clk_sys),
    .i_nrst      (i_nrst),
    .i_in_valid  (q_in_valid),
    .o_in_ready  (q_in_ready),
    .i_in_data   (q_in_data),
    .o_out_valid (q_out_valid),
    .i_out_ready (q_out_ready),
    .o_out_data  (q_out_data)
  );

  // ---------------------------------------------------------------
  // engine timing
  // ---------------------------------------------------------------
  dhlcd_eng_t                 eng_r;
  logic [dhlcd_pkg::TMR_W-1:0] tmr_r;
  logic                        pop;
  logic [1:0]                  ent_mask;
  logic                        ent_rs;
  logic                        ent_rw;
  logic [7:0]                  ent_data;
  logic                        ent_swrst;

  assign q_out_ready = (eng_r == DHLCD_IDLE);
  assign pop         = q_out_valid & q_out_ready;
  assign ent_mask    = q_out_data[dhlcd_pkg::ENT_MASK_LSB +: 2];
  assign ent_rs      = q_out_data[dhlcd_pkg::ENT_RS];
  assign ent_rw      = q_out_data[dhlcd_pkg::ENT_RW];
  assign ent_data    = q_out_data[7:0];
  assign ent_swrst   = ~ent_rs & ~ent_rw
                     & cmd_is(ent_data, dhlcd_pkg::CMD_FULL_MASK, dhlcd_pkg::CMD_SWRST);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      eng_r     <= DHLCD_IDLE;
      tmr_r     <= '0;
      rst_act_r <= 1'b0;
    end else begin
      case (eng_r)
        DHLCD_IDLE: begin
          if (pop) begin
            eng_r     <= DHLCD_HOLD;
            rst_act_r <= ent_swrst;
            tmr_r     <= ent_swrst ? dhlcd_pkg::TMR_W'(dhlcd_pkg::RST_CYCLES - 1)
                                   : dhlcd_pkg::TMR_W'(dhlcd_pkg::OP_CYCLES - 1);
          end
        end
        DHLCD_HOLD: begin
          if (tmr_r == '0) begin
            eng_r     <= DHLCD_IDLE;
            rst_act_r <= 1'b0;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        default: begin
          eng_r <= DHLCD_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // display ram, one bit per pixel, byte per page column
  // ---------------------------------------------------------------
  logic [7:0] ram [dhlcd_pkg::HALVES][dhlcd_pkg::RAM_WORDS];
  logic [6:0] col_r     [dhlcd_pkg::HALVES];
  logic [6:0] rmw_col_r [dhlcd_pkg::HALVES];
  logic [1:0] page_r    [dhlcd_pkg::HALVES];
  logic [4:0] start_r   [dhlcd_pkg::HALVES];
  logic [7:0] latch_r   [dhlcd_pkg::HALVES];
  logic       rmw_r     [dhlcd_pkg::HALVES];
  logic       disp_on_r [dhlcd_pkg::HALVES];

  always_ff @(posedge i_clk_sys) begin
    for (int h = 0; h < dhlcd_pkg::HALVES; h++) begin
      if (pop && ent_mask[h] && ent_rs && !ent_rw && (col_r[h] < dhlcd_pkg::COL_LIMIT)) begin
        ram[h][ram_addr(page_r[h], col_r[h])] <= ent_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-half address and control registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int h = 0; h < dhlcd_pkg::HALVES; h++) begin
        col_r[h]     <= dhlcd_pkg::COL_RST;
        rmw_col_r[h] <= dhlcd_pkg::COL_RST;
        page_r[h]    <= dhlcd_pkg::PAGE_RST;
        start_r[h]   <= dhlcd_pkg::START_RST;
        latch_r[h]   <= dhlcd_pkg::LATCH_RST;
        rmw_r[h]     <= 1'b0;
        disp_on_r[h] <= 1'b0;
      end
    end else if (pop) begin
      for (int h = 0; h < dhlcd_pkg::HALVES; h++) begin
        if (ent_mask[h]) begin
          if (ent_rs && !ent_rw) begin
            if (col_r[h] < dhlcd_pkg::COL_LIMIT) begin
              col_r[h] <= col_r[h] + 7'h01;
            end
          end else if (ent_rs && ent_rw) begin
            latch_r[h] <= (col_r[h] < dhlcd_pkg::COL_LIMIT)
                        ? ram[h][ram_addr(page_r[h], col_r[h])]
                        : dhlcd_pkg::LATCH_RST;
            if (!rmw_r[h] && (col_r[h] < dhlcd_pkg::COL_LIMIT)) begin
              col_r[h] <= col_r[h] + 7'h01;
            end
          end else if (ent_swrst) begin
            col_r[h]   <= dhlcd_pkg::COL_RST;
            page_r[h]  <= dhlcd_pkg::PAGE_RST;
            start_r[h] <= dhlcd_pkg::START_RST;
            rmw_r[h]   <= 1'b0;
          end else if (cmd_is(ent_data, dhlcd_pkg::CMD_FULL_MASK, dhlcd_pkg::CMD_RMW)) begin
            rmw_r[h]     <= 1'b1;
            rmw_col_r[h] <= col_r[h];
          end else if (cmd_is(ent_data, dhlcd_pkg::CMD_FULL_MASK, dhlcd_pkg::CMD_END)) begin
            rmw_r[h] <= 1'b0;
            col_r[h] <= rmw_col_r[h];
          end else if (cmd_is(ent_data, dhlcd_pkg::CMD_COL_MASK, dhlcd_pkg::CMD_COL_VAL)) begin
            col_r[h] <= ent_data[6:0];
          end else if (cmd_is(ent_data, dhlcd_pkg::CMD_PAGE_MASK, dhlcd_pkg::CMD_PAGE_VAL)) begin
            page_r[h] <= ent_data[1:0];
          end else if (cmd_is(ent_data, dhlcd_pkg::CMD_START_MASK,
                              dhlcd_pkg::CMD_START_VAL)) begin
            start_r[h] <= ent_data[4:0];
          end else if (cmd_is(ent_data, dhlcd_pkg::CMD_DISP_MASK, dhlcd_pkg::CMD_DISP_VAL)) begin
            disp_on_r[h] <= ent_data[0];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // host read data and bus drive
  // ---------------------------------------------------------------
  logic [7:0] status [dhlcd_pkg::HALVES];
  logic [7:0] bus_r;
  logic       hsel;

  always_comb begin
    for (int h = 0; h < dhlcd_pkg::HALVES; h++) begin
      status[h]                     = 8'h00;
      status[h][dhlcd_pkg::ST_BUSY]  = busy;
      status[h][dhlcd_pkg::ST_OFF]   = ~disp_on_r[h];
      status[h][dhlcd_pkg::ST_RESET] = rst_act_r;
      status[h][dhlcd_pkg::ST_PEND]  = q_out_valid | (eng_r != DHLCD_IDLE);
    end
  end

  assign hsel = sel_s[dhlcd_pkg::HALF_LEFT] ? 1'b0 : 1'b1;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_r <= 8'h00;
    end else begin
      bus_r <= rs_s ? latch_r[hsel] : status[hsel];
    end
  end

  assign o_bus_data = bus_r;
  assign o_bus_oe_n = ~((sel_s != 2'b00) & rw_s);

  // ---------------------------------------------------------------
  // pixel scan port: row offset by start line
  // ---------------------------------------------------------------
  logic [4:0] scan_line;
  logic       pix_r;

  assign scan_line = i_pix_row + start_r[i_pix_half];

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pix_r <= 1'b0;
    end else if (i_pix_col < dhlcd_pkg::COL_LIMIT) begin
      pix_r <= ram[i_pix_half][ram_addr(scan_line[4:3], i_pix_col)][scan_line[2:0]];
    end else begin
      pix_r <= 1'b0;
    end
  end

  assign o_pix              = pix_r;
  assign o_start_line_left  = start_r[dhlcd_pkg::HALF_LEFT];
  assign o_start_line_right = start_r[dhlcd_pkg::HALF_RIGHT];
  assign o_display_on_left  = disp_on_r[dhlcd_pkg::HALF_LEFT];
  assign o_display_on_right = disp_on_r[dhlcd_pkg::HALF_RIGHT];

endmodule

// ==== tb/dhlcd_host_port_asserts.sv ====
// port checker for the two-half lcd host port
`timescale 1ns/1ps
module dhlcd_host_port_asserts (
  input wire logic       i_clk_sys,
  input wire logic       i_nrst,
  input wire logic       i_register_select,
  input wire logic       i_read_not_write,
  input wire logic       i_left_half_select,
  input wire logic       i_right_half_select,
  input wire logic [7:0] o_bus_data,
  input wire logic       o_bus_oe_n,
  input wire logic [6:0] i_pix_col,
  input wire logic       o_pix,
  input wire logic [4:0] o_start_line_left,
  input wire logic [4:0] o_start_line_right,
  input wire logic       o_display_on_left,
  input wire logic       o_display_on_right
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  // cycles since either select was last high; wide enough for a full queue of resets
  logic [10:0] idle_r;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      idle_r <= 11'h000;
    end else if (i_left_half_select || i_right_half_select) begin
      idle_r <= 11'h000;
    end else if (idle_r != 11'h7FF) begin
      idle_r <= idle_r + 11'h001;
    end
  end

  sequence s_sel_low;
    !(i_left_half_select || i_right_half_select);
  endsequence
  sequence s_left_rd;
    (i_left_half_select && i_read_not_write)[*4];
  endsequence
  sequence s_right_rd;
    (i_right_half_select && !i_left_half_select && i_read_not_write)[*4];
  endsequence
  sequence s_status_rd;
    (i_left_half_select && !i_register_select && i_read_not_write)[*4];
  endsequence

  property p_oe_idle;   s_sel_low[*3] |-> o_bus_oe_n; endproperty
  property p_oe_write;  (!i_read_not_write)[*3] |-> o_bus_oe_n; endproperty
  property p_oe_left;   s_left_rd |-> !o_bus_oe_n; endproperty
  property p_oe_right;  s_right_rd |-> !o_bus_oe_n; endproperty
  property p_oe_status; s_status_rd ##1 i_left_half_select |-> !o_bus_oe_n; endproperty
  property p_pix_col;   (i_pix_col >= 7'h50) |=> !o_pix; endproperty
  property p_start_hold;
    (idle_r >= 11'h700) |-> $stable(o_start_line_left) && $stable(o_start_line_right);
  endproperty
  property p_disp_hold;
    (idle_r >= 11'h700) |=> $stable({o_display_on_left, o_display_on_right});
  endproperty
  property p_rst_vals;
    !$past(i_nrst) |-> o_bus_oe_n && (o_bus_data == 8'h00) && (o_start_line_left == 5'h00);
  endproperty

  a_oe_idle:    assert property (p_oe_idle)    else $error("bus driven with no select");
  a_oe_write:   assert property (p_oe_write)   else $error("bus driven during write");
  a_oe_left:    assert property (p_oe_left)    else $error("left read not driven");
  a_oe_right:   assert property (p_oe_right)   else $error("right read not driven");
  a_oe_status:  assert property (p_oe_status)  else $error("status read not driven");
  a_pix_col:    assert property (p_pix_col)    else $error("pixel set past column end");
  a_start_hold: assert property (p_start_hold) else $error("start line moved while idle");
  a_disp_hold:  assert property (p_disp_hold)  else $error("display bit moved while idle");
  a_rst_vals:   assert property (p_rst_vals)   else $error("bad value after reset");
endmodule

bind dhlcd_host_port dhlcd_host_port_asserts u_chk (
  .i_clk_sys, .i_nrst, .i_register_select, .i_read_not_write, .i_left_half_select,
  .i_right_half_select, .o_bus_data, .o_bus_oe_n, .i_pix_col, .o_pix,
  .o_start_line_left, .o_start_line_right, .o_display_on_left, .o_display_on_right
);

// ==== tb/dhlcd_host_model.sv ====
// host processor model driving the parallel pins
`timescale 1ns/1ps
module dhlcd_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_dev_data,
  input  wire logic       i_dev_oe_n,
  output logic            o_register_select,
  output logic            o_read_not_write,
  output logic            o_left_half_select,
  output logic            o_right_half_select,
  output logic      [7:0] o_bus_data
);
  logic       drv = 1'b0;
  logic [7:0] dat = 8'h00;
  logic [7:0] last_r = 8'h00;

  // undriven bus drifts away from its last value
  assign o_bus_data = drv ? dat : (!i_dev_oe_n ? i_dev_data : ~last_r);
  always_ff @(posedge i_clk_sys) last_r <= o_bus_data;

  initial begin
    o_register_select   = 1'b0;
    o_read_not_write    = 1'b1;
    o_left_half_select  = 1'b0;
    o_right_half_select = 1'b0;
  end

  task automatic access(input logic [1:0] m, input logic rs, input logic rw,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk_sys);
    o_register_select = rs;
    o_read_not_write  = rw;
    dat = d;
    drv = !rw;
    {o_right_half_select, o_left_half_select} = m;
    repeat (5) @(negedge i_clk_sys);
    q = o_bus_data;
    o_left_half_select  = 1'b0;
    o_right_half_select = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    drv = 1'b0;
  endtask
endmodule

// ==== tb/dhlcd_host_port_test.sv ====
// self-checking bench for the two-half lcd host port
`timescale 1ns/1ps
module dhlcd_host_port_test;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       pix_half = 1'b0;
  logic [4:0] pix_row = 5'h00;
  logic [6:0] pix_col = 7'h00;
  logic       rs, rw, sel_l, sel_r, oe_n, pix, on_l, on_r;
  logic [7:0] bus_in, bus_out;
  logic [4:0] st_l, st_r;
  int         failures = 0;
  int         total_checks = 0;

  initial forever #2.5 clk = ~clk;

  dhlcd_host_model host (.i_clk_sys(clk), .i_dev_data(bus_out), .i_dev_oe_n(oe_n),
    .o_register_select(rs), .o_read_not_write(rw), .o_left_half_select(sel_l),
    .o_right_half_select(sel_r), .o_bus_data(bus_in));

  dhlcd_host_port dut (.i_clk_sys(clk), .i_nrst(nrst), .i_register_select(rs),
    .i_read_not_write(rw), .i_left_half_select(sel_l), .i_right_half_select(sel_r),
    .i_bus_data(bus_in), .o_bus_data(bus_out), .o_bus_oe_n(oe_n), .i_pix_half(pix_half),
    .i_pix_row(pix_row), .i_pix_col(pix_col), .o_pix(pix), .o_start_line_left(st_l),
    .o_start_line_right(st_r), .o_display_on_left(on_l), .o_display_on_right(on_r));

  // ---------------------------------------------------------------
  // checking and bus helpers
  // ---------------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic idle(input logic [1:0] m);
    logic [7:0] q;
    int         n;
    for (int h = 0; h < 2; h++) begin
      n = 0;
      if (m[h]) begin
        do begin
          host.access(2'b01 << h, 1'b0, 1'b1, 8'h00, q);
          n++;
        end while (((q & 8'h88) !== 8'h00) && n < 100);
        if (n >= 100) begin
          chk8("idle_wait", 8'h00, q & 8'h88);
          test_done();
        end
      end
    end
  endtask

  task automatic cmd(input logic [1:0] m, input logic [7:0] c);
    logic [7:0] q;
    idle(m);
    host.access(m, 1'b0, 1'b0, c, q);
  endtask

  task automatic wr(input logic [1:0] m, input logic [7:0] d);
    logic [7:0] q;
    idle(m);
    host.access(m, 1'b1, 1'b0, d, q);
  endtask

  task automatic rd(input logic [1:0] m, output logic [7:0] q);
    idle(m);
    host.access(m, 1'b1, 1'b1, 8'h00, q);
  endtask

  task automatic pix_chk(input logic h, input logic [4:0] r, input logic [6:0] c, input logic e);
    @(negedge clk);
    pix_half = h;
    pix_row  = r;
    pix_col  = c;
    @(negedge clk);
    chk8("pixel", {7'h00, e}, {7'h00, pix});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] q;
    chk8("oe_n", 8'h01, {7'h00, oe_n});
    chk8("start_left", 8'h00, {3'h0, st_l});
    host.access(2'b01, 1'b0, 1'b1, 8'h00, q);
    chk8("status_left", 8'h20, q);
    host.access(2'b10, 1'b0, 1'b1, 8'h00, q);
    chk8("status_right", 8'h20, q);
  endtask

  task automatic t_write_read;
    logic [7:0] q;
    cmd(2'b11, 8'hBA);
    cmd(2'b11, 8'h05);
    wr(2'b01, 8'hAA);
    wr(2'b01, 8'h55);
    wr(2'b10, 8'h0F);
    cmd(2'b01, 8'h05);
    rd(2'b01, q);
    rd(2'b01, q);
    chk8("read0", 8'hAA, q);
    rd(2'b01, q);
    chk8("read1", 8'h55, q);
    cmd(2'b10, 8'h05);
    rd(2'b10, q);
    rd(2'b10, q);
    chk8("read_right", 8'h0F, q);
    pix_chk(1'b0, 5'd16, 7'h05, 1'b0);
    pix_chk(1'b0, 5'd23, 7'h05, 1'b1);
    pix_chk(1'b0, 5'd16, 7'h06, 1'b1);
    pix_chk(1'b1, 5'd17, 7'h05, 1'b1);
    pix_chk(1'b1, 5'd23, 7'h05, 1'b0);
  endtask

  task automatic t_sat;
    logic [7:0] q;
    cmd(2'b01, 8'h4F);
    wr(2'b01, 8'h11);
    wr(2'b01, 8'h22);
    wr(2'b01, 8'h33);
    cmd(2'b01, 8'h4F);
    rd(2'b01, q);
    rd(2'b01, q);
    chk8("sat_read0", 8'h11, q);
    rd(2'b01, q);
    chk8("sat_read1", 8'h00, q);
    pix_chk(1'b0, 5'd16, 7'h50, 1'b0);
  endtask

  task automatic t_rmw;
    logic [7:0] q;
    cmd(2'b01, 8'h10);
    wr(2'b01, 8'h77);
    cmd(2'b01, 8'h10);
    cmd(2'b01, 8'hE0);
    rd(2'b01, q);
    rd(2'b01, q);
    chk8("rmw_read", 8'h77, q);
    wr(2'b01, 8'h99);
    cmd(2'b01, 8'hEE);
    rd(2'b01, q);
    rd(2'b01, q);
    chk8("rmw_write", 8'h99, q);
  endtask

  task automatic t_halves;
    logic [7:0] q;
    cmd(2'b01, 8'hC5);
    cmd(2'b10, 8'hC9);
    cmd(2'b11, 8'hAF);
    idle(2'b11);
    chk8("start_left", 8'h05, {3'h0, st_l});
    chk8("start_right", 8'h09, {3'h0, st_r});
    chk8("display_on", 8'h03, {6'h00, on_r, on_l});
    host.access(2'b10, 1'b0, 1'b1, 8'h00, q);
    chk8("status_on", 8'h00, q);
    cmd(2'b10, 8'hAE);
    idle(2'b10);
    chk8("display_off", 8'h01, {6'h00, on_r, on_l});
  endtask

  task automatic t_busy;
    logic [7:0] q;
    cmd(2'b01, 8'hE2);
    host.access(2'b01, 1'b0, 1'b1, 8'h00, q);
    chk8("busy_status", 8'h90, q & 8'h90);
    host.access(2'b01, 1'b0, 1'b0, 8'hBB, q);
    wr(2'b01, 8'hFF);
    chk8("start_reset", 8'h00, {3'h0, st_l});
    pix_chk(1'b0, 5'd0, 7'h00, 1'b1);
    repeat (1900) @(negedge clk);
  endtask

  task automatic t_midrst;
    logic [7:0] q;
    @(negedge clk);
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    chk8("rst_start", 8'h00, {3'h0, st_r});
    chk8("rst_disp", 8'h00, {6'h00, on_r, on_l});
    nrst = 1'b1;
    host.access(2'b01, 1'b0, 1'b1, 8'h00, q);
    chk8("rst_status", 8'h20, q);
  endtask

  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_write_read();
    t_sat();
    t_rmw();
    t_halves();
    t_busy();
    t_midrst();
    test_done();
  end
endmodule
